// file: rtl/uesf_consts.vh
// Register indices, bit positions and reset values of the endpoint status block
`ifndef UESF_CONSTS_VH
`define UESF_CONSTS_VH
// Register indices (byte address is four times the index)
`define UESF_A_EVENT 8'he8
`define UESF_A_SELECT 8'he9
`define UESF_A_CFG0 8'hea
`define UESF_A_CFG1 8'heb
`define UESF_A_IEN 8'hec
`define UESF_A_CTRL 8'hed
`define UESF_A_STA0 8'hee
`define UESF_A_STA1 8'hef
// Event register bits
`define UESF_B_HAND 7
`define UESF_B_NAKIN 6
`define UESF_B_NAKOUT 4
`define UESF_B_SETUP 3
`define UESF_B_OUTRX 2
`define UESF_B_STALLED 1
`define UESF_B_TXRDY 0
// Status and control bits
`define UESF_B_OVF 6
`define UESF_B_UNF 5
`define UESF_B_FLOW_EN 7
`define UESF_B_CLAIM 1
`define UESF_B_STALL_SET 5
`define UESF_B_STALL_CLR 4
`define UESF_B_TOG_RST 3
// Endpoint type codes
`define UESF_T_CONTROL 2'b00
`define UESF_T_ISO 2'b01
// Reset values
`define UESF_RST_BYTE 8'h00
`define UESF_RST_SEL 3'h0
// Buffer capacity in bytes, smallest bank in bytes
`define UESF_CAPACITY 176
`define UESF_MIN_BANK 9'h008
`endif

// file: rtl/uesf_avs.v
// Avalon-MM slave front end with one wait state
`timescale 1ns/1ps
`include "uesf_consts.vh"
module uesf_avs (
	// Clock and reset
	input wire sys_clk_i,
	input wire reset_i,
	// Avalon-MM side
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [3:0] avs_byteenable_i,
	output wire avs_waitrequest_o,
	output reg [31:0] avs_readdata_o,
	// Register file side
	input wire [7:0] rd_data_i,
	output wire wr_stb_o
);
	reg ack_r;

	// Second cycle of every request completes it
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			ack_r <= 1'b0;
			avs_readdata_o <= 32'h0000_0000;
		end else begin
			ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
			if (avs_read_i & ~ack_r)
				avs_readdata_o <= {24'h00_0000, rd_data_i}; // Upper bits read zero
		end
	end

	// Handshake and write strobe on the completing edge
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
	assign wr_stb_o = avs_write_i & ack_r & avs_byteenable_i[0];
endmodule

// file: rtl/uesf_memory_claim.v
// Endpoint memory allocator with capacity check
`timescale 1ns/1ps
`include "uesf_consts.vh"
module uesf_memory_claim #(
	parameter NUM_EP = 5,
	parameter [10:0] CAPACITY = `UESF_CAPACITY
) (
	// Clock and reset
	input wire sys_clk_i,
	input wire reset_i,
	// Requests
	input wire claim_i,
	input wire free_i,
	input wire [2:0] ep_i,
	input wire [2:0] size_i,
	input wire [1:0] bank_i,
	// Result
	output reg fit_vld_o,
	output reg fit_o
);
	reg [8:0] amt_r [0:NUM_EP-1];
	reg [10:0] others;
	reg [8:0] req;
	reg ok;
	integer k;
	integer j;

	// Requested amount and memory held by the other endpoints
	always @*begin
		others = 11'h000;
		for (k = 0; k < NUM_EP; k = k + 1)
			if (k != ep_i)
				others = others + {2'b00, amt_r[k]};
		req = (`UESF_MIN_BANK << size_i[1:0]) << bank_i[0];
		ok = ~size_i[2] & ~bank_i[1] & (others + {2'b00, req} <= CAPACITY);
	end

	// Reserve on claim, release on free
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			for (j = 0; j < NUM_EP; j = j + 1)
				amt_r[j] <= 9'h000;
			fit_vld_o <= 1'b0;
			fit_o <= 1'b0;
		end else begin
			fit_vld_o <= claim_i;
			if (claim_i) begin
				fit_o <= ok;
				amt_r[ep_i] <= ok ? req : 9'h000;
			end else if (free_i) begin
				amt_r[ep_i] <= 9'h000;
			end
		end
	end
endmodule

// file: rtl/uesf_top.v
// Per-endpoint status, bank hand-off and event flags with register access
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`include "uesf_consts.vh"
// Functional notes
// - Claim bit set reserves size times bank count for selected endpoint.
// - Claim bit cleared releases the selected endpoint's memory.
// - Every claim updates the fits flag from the capacity check.
// - Iso overrun sets a flag; zero write clears; flow enable gates interrupt.
// - Iso starve sets a flag; zero write clears; flow enable gates interrupt.
// - Toggle field: 00 DATA0, 01 DATA1; last OUT received or next IN.
// - Busy bank count 0, 1 or 2 of loaded or received banks.
// - SETUP reception records direction of the following packet.
// - Active bank index reports bank 0 or bank 1.
// - Hand-off bit accepts only zero writes; ones are ignored.
// - OUT/control: packet sets hand-off and received flag; zero releases bank.
// - IN: free bank sets hand-off and transmit-ready; zero commits bank.
// - NAK sent to IN sets a flag; zero write clears it.
// - Access allowed when IN bank has room or OUT bank has data.
// - Access allowed held low during stall request or flow error.
// - NAK sent to OUT sets a flag; zero write clears it.
// - Error-free SETUP sets setup flag; zero write clears it.
// - OUT endpoints: bit 2 is the received flag, zero write clears.
// - IN endpoints: writing one to bit 2 cancels the last loaded bank.
// - STALL sent or iso OUT CRC error sets stall flag; zero clears.
// - All endpoint registers act on the selected endpoint number.
// - Transmit-ready set when current IN bank is free; zero clears.
// - Flow interrupt needs flow enable, global enable and the flag.
module uesf_top #(
	parameter NUM_EP = 5
) (
	// Clock and reset
	input wire sys_clk_i,
	input wire reset_i,
	// Avalon-MM register bus (word index address)
	input wire [7:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output wire avs_waitrequest_o,
	output wire [31:0] avs_readdata_o,
	// USB engine events, same clock, one-cycle pulses
	input wire [2:0] ev_ep_i,
	input wire ev_overflow_i,
	input wire ev_underflow_i,
	input wire ev_nak_in_i,
	input wire ev_nak_out_i,
	input wire ev_setup_i,
	input wire ev_setup_dir_i,
	input wire ev_out_pkt_i,
	input wire ev_out_toggle_i,
	input wire ev_in_sent_i,
	input wire ev_stall_sent_i,
	input wire ev_iso_crc_i,
	// Data path levels per endpoint
	input wire [NUM_EP-1:0] bank_full_i,
	input wire [NUM_EP-1:0] bank_empty_i,
	input wire irq_global_en_i,
	// Outputs to the controller
	output wire [2:0] endpoint_select_o,
	output wire [NUM_EP-1:0] stall_request_o,
	output wire [NUM_EP-1:0] ep_irq_o,
	output wire [NUM_EP-1:0] bank_commit_o,
	output wire [NUM_EP-1:0] cancel_loaded_bank_o
);
	reg [2:0] endpoint_select_r;
	reg [7:0] rd_mux;
	wire wr_stb;
	wire [7:0] wd;
	wire [NUM_EP*8-1:0] ev_bus;
	wire [NUM_EP*8-1:0] sta0_bus;
	wire [NUM_EP*8-1:0] sta1_bus;
	wire [NUM_EP*8-1:0] cfg0_bus;
	wire [NUM_EP*8-1:0] cfg1_bus;
	wire [NUM_EP*8-1:0] ien_bus;
	wire [NUM_EP*8-1:0] ctrl_bus;
	wire [NUM_EP-1:0] fits_bus;
	wire wr_cfg1;
	wire claim_set;
	wire claim_clr;
	wire fit_vld;
	wire fit;
	reg [2:0] fit_ep_r;
	wire [NUM_EP-1:0] claim_bus;

	assign wd = avs_writedata_i[7:0];
	assign endpoint_select_o = endpoint_select_r;

	// Bus front end
	uesf_avs u_avs (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_waitrequest_o(avs_waitrequest_o),
		.avs_readdata_o(avs_readdata_o),
		.rd_data_i(rd_mux),
		.wr_stb_o(wr_stb)
	);

	// Claim edges of the selected endpoint
	assign wr_cfg1 = wr_stb & (avs_address_i == `UESF_A_CFG1);
	assign claim_set = wr_cfg1 & wd[`UESF_B_CLAIM];
	assign claim_clr = wr_cfg1 & ~wd[`UESF_B_CLAIM] & claim_bus[endpoint_select_r];

	// Memory allocator
	uesf_memory_claim #(
		.NUM_EP(NUM_EP)
	) u_memory_claim (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.claim_i(claim_set),
		.free_i(claim_clr),
		.ep_i(endpoint_select_r),
		.size_i(wd[6:4]),
		.bank_i(wd[3:2]),
		.fit_vld_o(fit_vld),
		.fit_o(fit)
	);

	// Endpoint select register and claim target
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			endpoint_select_r <= `UESF_RST_SEL;
			fit_ep_r <= `UESF_RST_SEL;
		end else begin
			if (wr_stb & (avs_address_i == `UESF_A_SELECT))
				endpoint_select_r <= wd[2:0];
			if (claim_set)
				fit_ep_r <= endpoint_select_r;
		end
	end

	// Read mux of the selected endpoint
	always @*begin
		case (avs_address_i)
			`UESF_A_SELECT: rd_mux = {5'h00, endpoint_select_r};
			`UESF_A_EVENT: rd_mux = ev_bus[endpoint_select_r*8 +: 8];
			`UESF_A_STA0: rd_mux = sta0_bus[endpoint_select_r*8 +: 8];
			`UESF_A_STA1: rd_mux = sta1_bus[endpoint_select_r*8 +: 8];
			`UESF_A_CFG0: rd_mux = cfg0_bus[endpoint_select_r*8 +: 8];
			`UESF_A_CFG1: rd_mux = cfg1_bus[endpoint_select_r*8 +: 8];
			`UESF_A_IEN: rd_mux = ien_bus[endpoint_select_r*8 +: 8];
			`UESF_A_CTRL: rd_mux = ctrl_bus[endpoint_select_r*8 +: 8];
			default: rd_mux = 8'h00;
		endcase
	end

	genvar i;
	generate
		for (i = 0; i < NUM_EP; i = i + 1) begin : g_ep
			reg [1:0] type_r;
			reg dir_r;
			reg [2:0] size_r;
			reg [1:0] bank_r;
			reg claim_r;
			reg [7:0] ien_r;
			reg stall_r;
			reg config_fits_flag_r;
			reg ovf_r;
			reg unf_r;
			reg tog_r;
			reg [1:0] busy_r;
			reg cur_r;
			reg cdir_r;
			reg hand_r;
			reg nakin_r;
			reg nakout_r;
			reg setup_r;
			reg outrx_r;
			reg stalled_r;
			reg txrdy_r;
			reg [1:0] busy_nxt;
			reg hand_nxt;
			reg cur_nxt;
			wire sel;
			wire hit;
			wire is_ctl;
			wire is_in;
			wire is_iso;
			wire two;
			wire wr_ev;
			wire wr_sta0;
			wire pkt;
			wire rel;
			wire kill;
			wire sent;
			wire access_allowed_flag;
			wire [7:0] flags;

			assign sel = (endpoint_select_r == i);
			assign hit = (ev_ep_i == i);
			assign is_ctl = (type_r == `UESF_T_CONTROL);
			assign is_in = dir_r & ~is_ctl;
			assign is_iso = (type_r == `UESF_T_ISO);
			assign two = bank_r[0];
			assign wr_ev = wr_stb & sel & (avs_address_i == `UESF_A_EVENT);
			assign wr_sta0 = wr_stb & sel & (avs_address_i == `UESF_A_STA0);

			// Bank traffic of this endpoint
			assign pkt = ~is_in & hit & (ev_out_pkt_i | (is_ctl & ev_setup_i));
			assign rel = wr_ev & ~wd[`UESF_B_HAND] & hand_r;
			assign kill = is_in & wr_ev & wd[`UESF_B_OUTRX] & (busy_r != 2'b00);
			assign sent = is_in & hit & ev_in_sent_i & (busy_r != 2'b00);

			// Next bank count, index and hand-off
			always @*begin
				busy_nxt = busy_r;
				cur_nxt = cur_r;
				hand_nxt = hand_r;
				if (is_in) begin
					if (rel & ~kill & ~sent)
						busy_nxt = busy_r + 2'b01;
					else if (~rel & (kill ^ sent))
						busy_nxt = busy_r - 2'b01;
					else if (~rel & kill & sent)
						busy_nxt = busy_r - 2'b10;
					if (two & (rel ^ kill))
						cur_nxt = ~cur_r;
					hand_nxt = claim_r & (busy_nxt < (two ? 2'b10 : 2'b01));
				end else begin
					if (pkt & ~rel & (busy_r < (two ? 2'b10 : 2'b01)))
						busy_nxt = busy_r + 2'b01;
					else if (rel & ~pkt)
						busy_nxt = busy_r - 2'b01;
					if (rel & two & ~is_ctl)
						cur_nxt = ~cur_r;
					hand_nxt = pkt | (hand_r & ~rel) | (rel & (busy_nxt != 2'b00));
				end
			end

			// Allowed access for non-control endpoints
			assign access_allowed_flag = ~is_ctl & ~stall_r & ~ovf_r & ~unf_r & hand_r
				& (is_in ? ~bank_full_i[i] : ~bank_empty_i[i]);

			assign flags = {hand_r, nakin_r, access_allowed_flag, nakout_r, setup_r, outrx_r, stalled_r,
				txrdy_r};

			// Endpoint state
			always @(posedge sys_clk_i) begin
				if (reset_i) begin
					type_r <= 2'b00;
					dir_r <= 1'b0;
					size_r <= 3'h0;
					bank_r <= 2'b00;
					claim_r <= 1'b0;
					ien_r <= `UESF_RST_BYTE;
					stall_r <= 1'b0;
					config_fits_flag_r <= 1'b0;
					ovf_r <= 1'b0;
					unf_r <= 1'b0;
					tog_r <= 1'b0;
					busy_r <= 2'b00;
					cur_r <= 1'b0;
					cdir_r <= 1'b0;
					hand_r <= 1'b0;
					nakin_r <= 1'b0;
					nakout_r <= 1'b0;
					setup_r <= 1'b0;
					outrx_r <= 1'b0;
					stalled_r <= 1'b0;
					txrdy_r <= 1'b0;
				end else begin
					// Configuration writes
					if (wr_stb & sel & (avs_address_i == `UESF_A_CFG0)) begin
						type_r <= wd[7:6];
						dir_r <= wd[0];
					end
					if (wr_cfg1 & sel) begin
						size_r <= wd[6:4];
						bank_r <= wd[3:2];
						claim_r <= wd[`UESF_B_CLAIM];
					end
					if (wr_stb & sel & (avs_address_i == `UESF_A_IEN))
						ien_r <= {wd[7:6], 1'b0, wd[4:0]};
					if (fit_vld & (fit_ep_r == i))
						config_fits_flag_r <= fit;
					// Stall request, cleared by clear write, STALL sent or new SETUP, set by write
					if (wr_stb & sel & (avs_address_i == `UESF_A_CTRL) & wd[`UESF_B_STALL_SET])
						stall_r <= 1'b1;
					else if ((wr_stb & sel & (avs_address_i == `UESF_A_CTRL)
						& wd[`UESF_B_STALL_CLR]) | (hit & (ev_stall_sent_i | ev_setup_i)))
						stall_r <= 1'b0;
					// Flow errors
					ovf_r <= (ovf_r & ~(wr_sta0 & ~wd[`UESF_B_OVF]))
						| (is_iso & hit & ev_overflow_i);
					unf_r <= (unf_r & ~(wr_sta0 & ~wd[`UESF_B_UNF]))
						| (is_iso & hit & ev_underflow_i);
					// Data toggle
					if (wr_stb & sel & (avs_address_i == `UESF_A_CTRL) & wd[`UESF_B_TOG_RST])
						tog_r <= 1'b0;
					else if (~is_in & hit & ev_out_pkt_i)
						tog_r <= ev_out_toggle_i;
					else if (sent)
						tog_r <= ~tog_r;
					if (hit & ev_setup_i)
						cdir_r <= ev_setup_dir_i;
					// Banks
					busy_r <= busy_nxt;
					cur_r <= cur_nxt;
					hand_r <= hand_nxt;
					// Event flags, set wins over the acknowledging zero write
					nakin_r <= (nakin_r & ~(wr_ev & ~wd[`UESF_B_NAKIN]))
						| (hit & ev_nak_in_i);
					nakout_r <= (nakout_r & ~(wr_ev & ~wd[`UESF_B_NAKOUT]))
						| (hit & ev_nak_out_i);
					setup_r <= (setup_r & ~(wr_ev & ~wd[`UESF_B_SETUP]))
						| (is_ctl & hit & ev_setup_i);
					outrx_r <= (outrx_r & ~(~is_in & wr_ev & ~wd[`UESF_B_OUTRX]))
						| (hit & ~is_in & ev_out_pkt_i);
					stalled_r <= (stalled_r & ~(wr_ev & ~wd[`UESF_B_STALLED]))
						| (hit & (ev_stall_sent_i | (is_iso & ~is_in & ev_iso_crc_i)));
					txrdy_r <= (txrdy_r & ~(wr_ev & ~wd[`UESF_B_TXRDY]))
						| (is_in & hand_nxt & ~hand_r);
				end
			end

			// Register images
			assign ev_bus[i*8 +: 8] = flags;
			assign sta0_bus[i*8 +: 8] = {config_fits_flag_r, ovf_r, unf_r, 1'b0, 1'b0, tog_r, busy_r};
			assign sta1_bus[i*8 +: 8] = {5'h00, cdir_r, 1'b0, cur_r};
			assign cfg0_bus[i*8 +: 8] = {type_r, 5'h00, dir_r};
			assign cfg1_bus[i*8 +: 8] = {1'b0, size_r, bank_r, claim_r, 1'b0};
			assign ien_bus[i*8 +: 8] = ien_r;
			assign ctrl_bus[i*8 +: 8] = {2'b00, stall_r, 5'h00};
			assign fits_bus[i] = config_fits_flag_r;
			assign claim_bus[i] = claim_r;

			// Controller side outputs
			assign stall_request_o[i] = stall_r;
			assign bank_commit_o[i] = is_in & rel;
			assign cancel_loaded_bank_o[i] = kill;
			assign ep_irq_o[i] = irq_global_en_i & (
				(ien_r[`UESF_B_FLOW_EN] & (ovf_r | unf_r))
				| |(ien_r & {1'b0, nakin_r, 1'b0, nakout_r, setup_r, outrx_r, stalled_r,
				txrdy_r}));
		end
	endgenerate
endmodule

// file: verif/uesf_host.sv
// Host stand-in that raises engine event pulses toward the block
`timescale 1ns/1ps
module uesf_host (
	// Clock
	input wire sys_clk_i,
	// Event pulses, endpoint and qualifier
	output reg [8:0] ev_o,
	output reg [2:0] ev_ep_o,
	output reg dir_o
);
	// Quiet lines at time zero
	initial begin
		ev_o = 9'h000;
		ev_ep_o = 3'h0;
		dir_o = 1'b0;
	end
	// One-cycle pulse; endpoint and qualifier scrambled once it ends
	task automatic send(input int k, input [2:0] ep, input d);
		begin
			@(posedge sys_clk_i);
			ev_o <= 9'h001 << k;
			ev_ep_o <= ep;
			dir_o <= d;
			@(posedge sys_clk_i);
			ev_o <= 9'h000;
			ev_ep_o <= ~ep;
			dir_o <= ~d;
		end
	endtask
endmodule

// file: verif/uesf_chk.sv
// Port assertions for the endpoint status block
`timescale 1ns/1ps
module uesf_chk #(
	parameter NUM_EP = 5
) (
	// Clock, reset and register bus
	input wire sys_clk_i,
	input wire reset_i,
	input wire [7:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	input wire avs_waitrequest_o,
	// Events and outputs
	input wire [2:0] ev_ep_i,
	input wire ev_setup_i,
	input wire ev_stall_sent_i,
	input wire [2:0] endpoint_select_o,
	input wire [NUM_EP-1:0] stall_request_o,
	input wire [NUM_EP-1:0] bank_commit_o,
	input wire [NUM_EP-1:0] cancel_loaded_bank_o
);
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);
	// Finishing write, select data, selected endpoint as one-hot
	wire wr_done = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	wire [2:0] sel_data = avs_writedata_i[2:0];
	wire [NUM_EP-1:0] sel_hot = {{(NUM_EP-1){1'b0}}, 1'b1} << endpoint_select_o;
	property p_one_wait;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("long wait");
	property p_idle;
		!avs_read_i && !avs_write_i |-> !avs_waitrequest_o;
	endproperty
	a_idle: assert property (p_idle) else $error("idle wait");
	property p_sel_load;
		wr_done && avs_address_i == 8'he9 |=> endpoint_select_o == $past(sel_data);
	endproperty
	a_sel_load: assert property (p_sel_load) else $error("select not loaded");
	property p_sel_hold;
		!$stable(endpoint_select_o) && !$past(reset_i) |->
			$past(wr_done) && $past(avs_address_i) == 8'he9;
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("select moved");
	property p_commit;
		bank_commit_o != 0 |-> wr_done && avs_address_i == 8'he8 &&
			!avs_writedata_i[7] && bank_commit_o == sel_hot;
	endproperty
	a_commit: assert property (p_commit) else $error("stray commit");
	property p_cancel;
		cancel_loaded_bank_o != 0 |-> wr_done && avs_address_i == 8'he8 &&
			avs_writedata_i[2] && cancel_loaded_bank_o == sel_hot;
	endproperty
	a_cancel: assert property (p_cancel) else $error("stray cancel");
	property p_stall_set;
		wr_done && avs_address_i == 8'hed && avs_writedata_i[5] |=>
			(stall_request_o & sel_hot) == sel_hot;
	endproperty
	a_stall_set: assert property (p_stall_set) else $error("stall not set");
	property p_stall_drop;
		(ev_stall_sent_i || ev_setup_i) && !avs_write_i && ev_ep_i < NUM_EP |=>
			!stall_request_o[$past(ev_ep_i)];
	endproperty
	a_stall_drop: assert property (p_stall_drop) else $error("stall kept");
	// Main scenarios reached
	c_commit: cover property (bank_commit_o != 0);
	c_cancel: cover property (cancel_loaded_bank_o != 0);
	c_stall: cover property (stall_request_o != 0);
endmodule
bind uesf_top uesf_chk #(.NUM_EP(NUM_EP)) u_chk (
	.sys_clk_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i,
	.avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o, .ev_ep_i,
	.ev_setup_i, .ev_stall_sent_i, .endpoint_select_o, .stall_request_o,
	.bank_commit_o, .cancel_loaded_bank_o
);

// file: verif/testbench.sv
// Self-checking bench for the endpoint status block
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		checks_done++; \
		if ((g) !== (e)) begin \
			errors++; \
			$display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); \
		end \
	end
module testbench;
	// Bench drivers, design outputs, counters
	reg sys_clk_i = 1'b0;
	reg reset_i = 1'b1;
	reg [7:0] adr = 8'h00;
	reg rd = 1'b0;
	reg wr = 1'b0;
	reg [31:0] wdat = 32'h0;
	reg [4:0] empty = 5'h1f;
	reg [4:0] full = 5'h00;
	wire [2:0] sel_o;
	reg gie = 1'b0;
	reg [7:0] q;
	wire wait_o;
	wire [31:0] rdat;
	wire [8:0] ev;
	wire [2:0] ev_ep;
	wire ev_dir;
	wire [4:0] stall, irq, commit, cancel;
	int errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int ncommit = 0;
	int ncancel = 0;
	uesf_top #(.NUM_EP(5)) DUT (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_byteenable_i(4'h1), .avs_waitrequest_o(wait_o), .avs_readdata_o(rdat),
		.ev_ep_i(ev_ep), .ev_overflow_i(ev[0]), .ev_underflow_i(ev[1]),
		.ev_nak_in_i(ev[2]), .ev_nak_out_i(ev[3]), .ev_setup_i(ev[4]),
		.ev_setup_dir_i(ev_dir), .ev_out_pkt_i(ev[5]), .ev_out_toggle_i(ev_dir),
		.ev_in_sent_i(ev[6]), .ev_stall_sent_i(ev[7]), .ev_iso_crc_i(ev[8]),
		.bank_full_i(full), .bank_empty_i(empty), .irq_global_en_i(gie),
		.endpoint_select_o(sel_o), .stall_request_o(stall), .ep_irq_o(irq),
		.bank_commit_o(commit), .cancel_loaded_bank_o(cancel)
	);
	uesf_host host (.sys_clk_i(sys_clk_i), .ev_o(ev), .ev_ep_o(ev_ep), .dir_o(ev_dir));
	// Clock, cycle ceiling and pulse counts of endpoint 1
	always #2.5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		ncommit <= ncommit + (commit[1] === 1'b1);
		ncancel <= ncancel + (cancel[1] === 1'b1);
		if (cycles == 5000) begin
			errors++;
			report_and_stop();
		end
	end
	task report_and_stop;
		begin
			if (errors == 0 && checks_done > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	// One access, held until wait state ends; read data taken there
	task automatic bus(input w, input [7:0] a, input [7:0] d);
		begin
			@(posedge sys_clk_i);
			adr <= a;
			wdat <= {24'h000000, d};
			rd <= !w;
			wr <= w;
			do begin
				@(posedge sys_clk_i);
			end while (wait_o !== 1'b0);
			q = rdat[7:0];
			rd <= 1'b0;
			wr <= 1'b0;
		end
	endtask
	task automatic wreg(input [7:0] a, input [7:0] d);
		bus(1'b1, a, d);
	endtask
	// Masked read compare
	task automatic chk(input [7:0] a, input [7:0] m, input [7:0] e);
		begin
			bus(1'b0, a, 8'h00);
			`CHK(q & m, e)
		end
	endtask
	// Select, configure, claim; allocator answers two edges later
	task automatic ep_cfg(input [2:0] ep, input [7:0] c0, input [7:0] c1);
		begin
			wreg(8'he9, {5'h00, ep});
			wreg(8'hea, c0);
			wreg(8'heb, c1);
			repeat (2) @(posedge sys_clk_i);
		end
	endtask
	// Reset values, unmapped write ignored
	task automatic t_reset;
		begin
			wreg(8'h10, 8'hff);
			chk(8'h10, 8'hff, 8'h00);
			for (int i = 0; i < 8; i++)
				chk(8'he8 + i[7:0], 8'hff, 8'h00);
		end
	endtask
	// Control endpoint: SETUP, NAKs, stall, one and zero writes
	task automatic t_ctrl;
		begin
			ep_cfg(3'h0, 8'h00, 8'h02);
			wreg(8'hec, 8'h08);
			wreg(8'hed, 8'h20);
			gie <= 1'b1;
			@(posedge sys_clk_i);
			`CHK(stall[0], 1'b1)
			host.send(4, 3'h0, 1'b1);
			host.send(2, 3'h0, 1'b0);
			host.send(3, 3'h0, 1'b0);
			host.send(7, 3'h0, 1'b0);
			`CHK(stall[0], 1'b0)
			chk(8'he8, 8'hde, 8'hda);
			chk(8'hef, 8'h04, 8'h04);
			`CHK(irq[0], 1'b1)
			wreg(8'he8, 8'hff);
			chk(8'he8, 8'hde, 8'hda);
			wreg(8'he8, 8'h00);
			chk(8'he8, 8'hde, 8'h00);
			`CHK(irq[0], 1'b0)
			host.send(4, 3'h0, 1'b0);
			chk(8'hef, 8'h04, 8'h00);
		end
	endtask
	// IN endpoint, two banks of 64: commit, toggle, bank, kill
	task automatic t_in;
		begin
			ep_cfg(3'h1, 8'h81, 8'h36);
			chk(8'hee, 8'h80, 8'h80);
			chk(8'he8, 8'hff, 8'ha1);
			full <= 5'h02;
			chk(8'he8, 8'h20, 8'h00);
			full <= 5'h00;
			wreg(8'he8, 8'h7b);
			chk(8'hee, 8'h0f, 8'h01);
			chk(8'hef, 8'h03, 8'h01);
			`CHK(ncommit, 1)
			host.send(6, 3'h1, 1'b0);
			chk(8'hee, 8'h0f, 8'h04);
			// Load a bank again so the kill has something to cancel
			wreg(8'he8, 8'h7b);
			wreg(8'he8, 8'h84);
			chk(8'hee, 8'h03, 8'h00);
			wreg(8'he8, 8'h80);
			@(posedge sys_clk_i);
			`CHK(ncancel, 1)
			`CHK(ncommit, 2)
		end
	endtask
	// Iso OUT endpoint: errors, access allowed, stall request
	task automatic t_iso;
		begin
			ep_cfg(3'h3, 8'h40, 8'h02);
			empty <= 5'h17;
			host.send(5, 3'h3, 1'b1);
			chk(8'he8, 8'ha4, 8'ha4);
			chk(8'hee, 8'h8f, 8'h85);
			wreg(8'hec, 8'h80);
			host.send(0, 3'h3, 1'b0);
			chk(8'hee, 8'h40, 8'h40);
			chk(8'he8, 8'h20, 8'h00);
			`CHK(irq[3], 1'b1)
			gie <= 1'b0;
			@(posedge sys_clk_i);
			`CHK(irq[3], 1'b0)
			gie <= 1'b1;
			wreg(8'hee, 8'hbf);
			host.send(1, 3'h3, 1'b0);
			chk(8'hee, 8'h60, 8'h20);
			wreg(8'hee, 8'hdf);
			chk(8'hee, 8'h20, 8'h00);
			chk(8'he8, 8'h20, 8'h20);
			wreg(8'hed, 8'h20);
			chk(8'he8, 8'h20, 8'h00);
			`CHK(stall[3], 1'b1)
			wreg(8'hed, 8'h10);
			host.send(8, 3'h3, 1'b0);
			chk(8'he8, 8'h02, 8'h02);
			`CHK(stall[3], 1'b0)
		end
	endtask
	// Over capacity, release, reclaim
	task automatic t_memory_claim;
		begin
			ep_cfg(3'h2, 8'h80, 8'h32);
			`CHK(sel_o, 3'h2)
			chk(8'hee, 8'h80, 8'h00);
			ep_cfg(3'h1, 8'h81, 8'h34);
			ep_cfg(3'h2, 8'h80, 8'h32);
			chk(8'hee, 8'h80, 8'h80);
		end
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_ctrl();
		t_in();
		t_iso();
		t_memory_claim();
		report_and_stop();
	end
endmodule
